/* rtl/serial_latch_driver.sv */
// Twenty-stage shift register, transparent latch and blanked drivers
// Function
// - Each serial clock rising edge shifts data in, advancing all stages.
// - Cascade output updates from the shift register on each rising edge.
// - Blanking high forces all drivers low; latch contents stay untouched.
// - Blanking low lets each driver follow its latch bit.
// - Load high makes the latch transparent to the shift register.
// - Load low holds the latch regardless of shifting.
// - Falling edge of load captures the shift register into the latch.
// - A word is 20 bits, most significant first, then load drops.
// - Reset clears shift register and latch; drivers and cascade low.
`timescale 1ns/1ps
module serial_latch_driver (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load,
  input wire logic blank,
  output logic [19:0] driver_out,
  output logic cascade_out
);
  localparam int PIN_COUNT = 4;
  localparam int CLK_PIN = 0;
  localparam int DATA_PIN = 1;
  localparam int LOAD_PIN = 2;
  localparam int BLANK_PIN = 3;

  // Synchronised pin levels
  logic [PIN_COUNT-1:0] pin_raw;
  logic [1:0] sync_q [PIN_COUNT];
  logic clk_sync;
  logic data_sync;
  logic load_sync;
  logic blank_sync;
  logic clk_prev_q;
  logic load_prev_q;

  // Serial bit path
  logic bit_valid;
  logic fifo_data;
  logic fifo_valid;
  logic shift_en;

  // Shift register, latch and outputs
  logic [19:0] shift_q;
  logic [19:0] shift_d;
  logic [19:0] latch_q;
  logic [19:0] latch_d;
  logic load_fall;
  logic [19:0] driver_d;
  logic cascade_d;

  // Pins gathered in index order so one loop builds every synchroniser
  assign pin_raw = {blank, load, serial_data, serial_clk};

  // Two flops per pin; equal depth keeps data aligned with its clock edge
  // Limitation: data must hold a few core cycles past the clock rise
  for (genvar p = 0; p < PIN_COUNT; p++)
  begin : g_sync
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        sync_q[p] <= 2'h0;
      end
      else
      begin
        sync_q[p] <= {sync_q[p][0], pin_raw[p]};
      end
    end
  end

  // Only the second stage feeds logic; the first may be metastable
  assign clk_sync = sync_q[CLK_PIN][1];
  assign data_sync = sync_q[DATA_PIN][1];
  assign load_sync = sync_q[LOAD_PIN][1];
  assign blank_sync = sync_q[BLANK_PIN][1];

  // Serial clock history for rising-edge detection
  // Reset low matches the idle pin, so no false shift follows reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      clk_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= clk_sync;
    end
  end

  // Load history; reset low like the idle pin, so no false fall
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      load_prev_q <= 1'b0;
    end
    else
    begin
      load_prev_q <= load_sync;
    end
  end

  assign bit_valid = clk_sync && !clk_prev_q;

  // Sampled bits queue up; the shifter drains one per cycle
  // Depth four soaks up edges in flight; a stall needs a broken link
  bit_fifo #(
    .WIDTH(latch_driver_pkg::FIFO_WIDTH),
    .DEPTH(latch_driver_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data(data_sync),
    .in_valid(bit_valid),
    .in_ready(),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(1'b1)
  );

  // Drain never stalls; one bit per core cycle far outruns the link
  assign shift_en = fifo_valid;

  // first bit ends at the top
  always_comb
  begin
    shift_d = shift_q;
    if (shift_en)
    begin
      shift_d = {shift_q[latch_driver_pkg::WORD_MSB-1:0], fifo_data};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      shift_q <= latch_driver_pkg::SHIFT_RESET;
    end
    else
    begin
      shift_q <= shift_d;
    end
  end

  assign load_fall = load_prev_q && !load_sync;

  // Latch next value
  always_comb
  begin
    latch_d = latch_q;
    if (load_sync)
    begin
      latch_d = shift_d;
    end
    else if (load_fall)
    begin
      latch_d = shift_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      latch_q <= latch_driver_pkg::LATCH_RESET;
    end
    else
    begin
      latch_q <= latch_d;
    end
  end

  // blank forces low; else latch drives
  // one gate per driver, bit n from latch bit n
  for (genvar n = 0; n < latch_driver_pkg::WORD_BITS; n++)
  begin : g_drv
    assign driver_d[n] = blank_sync ?
      latch_driver_pkg::DRIVER_OFF[n] : latch_d[n];
  end

  // drivers start low; blank acts within three core cycles
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      driver_out <= latch_driver_pkg::DRIVER_OFF;
    end
    else
    begin
      driver_out <= driver_d;
    end
  end

  assign cascade_d = shift_d[latch_driver_pkg::WORD_MSB];

  // cascade starts low; registered so it mirrors shift_q
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cascade_out <= 1'b0;
    end
    else
    begin
      cascade_out <= cascade_d;
    end
  end
endmodule : serial_latch_driver

/* rtl/latch_driver_pkg.sv */
// Shared constants for the serial latch driver
package latch_driver_pkg;
  localparam int WORD_BITS = 20;
  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [19:0] SHIFT_RESET = 20'h00000;
  localparam logic [19:0] LATCH_RESET = 20'h00000;
  localparam logic [19:0] DRIVER_OFF = 20'h00000;
  localparam int WORD_MSB = 19;
  localparam int WORD_LSB = 0;
  localparam int DRIVER_FIRST = 0;
  localparam int DRIVER_LAST = 19;
  // Serial clock limits: period 200 ns, high and low 90 ns each
  localparam int CORE_PERIOD_NS = 10;
  localparam int LINK_PERIOD_MIN_NS = 200;
  localparam int LINK_PERIOD_MIN_CYC =
    (LINK_PERIOD_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
endpackage : latch_driver_pkg

/* rtl/bit_fifo.sv */
// Small valid/ready FIFO holding sampled serial bits
`timescale 1ns/1ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_q];

  // Storage, written by index
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : AW'(rd_q + 1'b1);
      end
      count_q <= (AW+1)'(count_q + push - pop);
    end
  end
endmodule : bit_fifo

/* testbench/sld_assertions.sv */
// Port checker for the serial latch driver
`timescale 1ns/1ps
module sld_check (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic load,
  input wire logic blank,
  input wire logic [19:0] driver_out,
  input wire logic cascade_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Outputs clear as reset lets go
  property p_rst_drv;
    $rose(rst_n) |-> driver_out == 20'h00000;
  endproperty
  a_rst_drv: assert property (p_rst_drv)
    else $error("drivers not clear");
  property p_rst_cas;
    $rose(rst_n) |-> !cascade_out;
  endproperty
  a_rst_cas: assert property (p_rst_cas)
    else $error("cascade not clear");

  // Five cycles cover the sync and register delay of blank
  property p_blank;
    blank[*5] |-> driver_out == 20'h00000;
  endproperty
  a_blank: assert property (p_blank)
    else $error("blank ignored");

  // Six idle cycles cover the sync and shift pipeline
  property p_quiet;
    $stable(serial_clk)[*6] |-> $stable(cascade_out);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("cascade moved");
  property p_hold;
    (!load && $stable(blank))[*6] |-> $stable(driver_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch moved");

  // Transparent and unblanked: top driver equals the last stage
  property p_tr;
    (load && !blank)[*8] |-> driver_out[19] == cascade_out;
  endproperty
  a_tr: assert property (p_tr)
    else $error("latch opaque");

  c_blank: cover property (blank[*5]);
  c_load: cover property ($fell(load));
  c_shift: cover property ($changed(cascade_out));
endmodule : sld_check
bind serial_latch_driver sld_check chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .serial_clk(serial_clk),
  .load(load),
  .blank(blank),
  .driver_out(driver_out),
  .cascade_out(cascade_out)
);

/* testbench/host_model.sv */
// Controller model driving the serial pins
`timescale 1ns/1ps
module host_model (
  output logic serial_clk,
  output logic serial_data,
  output logic load
);
  initial {serial_clk, serial_data, load} = 3'h0;
  task automatic send(input logic [19:0] w);
    for (int i = 19; i >= 0; i--)
    begin
      serial_data = w[i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    // Released data shows no stale level
    #40 serial_data = ~w[0];
  endtask : send
  task automatic pin_load(input logic v);
    #100 load = v;
  endtask : pin_load
endmodule : host_model

/* testbench/tb.sv */
// Self-checking bench for the serial latch driver
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic blank = 1'b0;
  logic serial_clk, serial_data, load, cascade_out;
  logic [19:0] driver_out, w, lat;
  int n_fail = 0;
  int tests_run = 0;
  serial_latch_driver uut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .load(load),
    .blank(blank),
    .driver_out(driver_out),
    .cascade_out(cascade_out)
  );
  host_model host (
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .load(load)
  );
  initial forever #5 core_clk = ~core_clk;
  function automatic logic [19:0] exp_drv(input logic [19:0] l, input logic b);
    return b ? 20'h00000 : l;
  endfunction : exp_drv
  task automatic check(input logic [20:0] exp);
    repeat (8) @(posedge core_clk);
    #1 tests_run++;
    if ({cascade_out, driver_out} !== exp)
    begin
      n_fail++;
      $display("unexpected %0t got %h exp %h", $time,
        {cascade_out, driver_out}, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Corner words first, then random ones
  initial
  begin
    void'($urandom(32'h17E0));
    lat = 20'h00000;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    check(21'h000000);
    $display("test reset done");
    for (int k = 0; k < 10; k++)
    begin
      w = k == 0 ? 20'hFFFFF : k == 1 ? 20'h80001 : 20'($urandom);
      host.send(w);
      check({w[19], lat});
      host.pin_load(1'b1);
      host.pin_load(1'b0);
      lat = w;
      check({w[19], lat});
      blank = k < 2 ? 1'b1 : 1'($urandom);
      check({w[19], exp_drv(lat, blank)});
      blank = 1'b0;
      check({w[19], lat});
      $display("test %0d done", k);
    end
    host.pin_load(1'b1);
    w = 20'($urandom);
    host.send(w);
    check({w[19], w});
    $display("test transparent done");
    print_verdict();
  end
  // Hang guard
  initial
  begin
    #400000;
    n_fail++;
    print_verdict();
  end
endmodule : tb
